// >>> rtl/osd_pkg.sv
/*
 * Shared constants and types for the on-screen display control bank:
 * byte addresses, field positions, reset values, font scan sizing.
 * Assumes a byte-wide register port driven by the serial control front end.
 */
package osd_pkg;

	localparam int            OSD_ADDR_W         = 16;
	localparam int            OSD_DATA_W         = 8;

	// register byte addresses
	localparam logic [15:0]   OSD_ADR_FONT_SEL   = 16'h8402;
	localparam logic [15:0]   OSD_ADR_VBLANK     = 16'h8403;
	localparam logic [15:0]   OSD_ADR_CHAR_HT    = 16'h8404;
	localparam logic [15:0]   OSD_ADR_HIGH_LO    = 16'h8405;
	localparam logic [15:0]   OSD_ADR_HIGH_HI    = 16'h8406;
	localparam logic [15:0]   OSD_ADR_LOW_LO     = 16'h8407;
	localparam logic [15:0]   OSD_ADR_LOW_HI     = 16'h8408;
	localparam logic [15:0]   OSD_ADR_SHADE_LO   = 16'h8409;
	localparam logic [15:0]   OSD_ADR_SHADE_HI   = 16'h840A;
	localparam logic [15:0]   OSD_ADR_CK_CTRL    = 16'h840D;
	localparam logic [15:0]   OSD_ADR_CK_RES_LO  = 16'h840E;
	localparam logic [15:0]   OSD_ADR_CK_RES_HI  = 16'h840F;

	// field positions and widths
	localparam int            OSD_VBLANK_W       = 7;
	localparam int            OSD_VBLANK_MSB     = 6;
	localparam int            OSD_CHAR_HT_W      = 8;
	localparam int            OSD_COLOR_W        = 9;
	localparam int            OSD_COLOR_HI_BIT   = 8;
	localparam int            OSD_CK_START_BIT   = 0;
	localparam int            OSD_CK_W           = 16;

	// reset values
	localparam logic [6:0]    OSD_VBLANK_RST     = 7'h00;
	localparam logic [7:0]    OSD_CHAR_HT_RST    = 8'h00;
	localparam logic [8:0]    OSD_COLOR_RST      = 9'h000;
	localparam logic [15:0]   OSD_CK_RES_RST     = 16'h0000;
	localparam logic [7:0]    OSD_RDATA_RST      = 8'h00;

	// font scan sizing
	localparam int            OSD_CK_CHARS       = 256;
	localparam int            OSD_CK_WORDS_CHAR  = 18;
	localparam int            OSD_ROM_DATA_W     = 12;
	localparam int            OSD_ROM_ADDR_W     = 13;
	localparam logic [12:0]   OSD_ROM_LAST       = 13'(OSD_CK_CHARS * OSD_CK_WORDS_CHAR - 1);
	localparam logic [12:0]   OSD_ROM_ADDR_RST   = 13'h0000;
	localparam logic [16:0]   OSD_CK_MODULUS     = 17'h0FFFF;

	typedef struct packed {
		logic [2:0] green;
		logic [2:0] red;
		logic [2:0] blue;
	} osd_color_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} osd_req_t;

	typedef enum logic [3:0] {
		OSD_CK_IDLE  = 4'b0001,
		OSD_CK_RUN   = 4'b0010,
		OSD_CK_DRAIN = 4'b0100,
		OSD_CK_DONE  = 4'b1000
	} osd_ck_state_t;

endpackage

// >>> rtl/osd_color_reg.sv
/*
 * One 9-bit colour setting split over two byte addresses.
 * Assumes one write request per cycle from the register bank.
 */
`timescale 1ns/1ps
module osd_color_reg
	import osd_pkg::*;
#(
	parameter logic [15:0] ADR_LO = 16'h0000,
	parameter logic [15:0] ADR_HI = 16'h0001
) (
	input  wire logic       clk,   // system clock
	input  wire logic       rst,   // async reset, high
	input  wire osd_pkg::osd_req_t req,   // register request
	output osd_pkg::osd_color_t    color  // stored colour
);
	logic [8:0] color_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			color_q <= OSD_COLOR_RST;
		end else if (req.wr && req.addr == ADR_LO) begin
			color_q[7:0] <= req.wdata;
		end else if (req.wr && req.addr == ADR_HI) begin
			color_q[OSD_COLOR_HI_BIT] <= req.wdata[0];
		end
	end

	assign color = osd_color_t'(color_q);
endmodule

// >>> rtl/osd_cksum.sv
/*
 * Font ROM signature engine: scans every ROM word in order and sums
 * modulo 65535. Assumes a ROM with one cycle of read latency.
 */
`timescale 1ns/1ps
module osd_cksum
	import osd_pkg::*;
(
	input  wire logic        clk,       // system clock
	input  wire logic        rst,       // async reset, high
	input  wire logic        start,     // start level
	input  wire logic [11:0] rom_data,  // rom word, one cycle after address
	output logic      [12:0] rom_addr,  // rom word address
	output logic             done,      // one-cycle finish pulse
	output logic      [15:0] sum        // final sum, valid with done
);
	osd_ck_state_t state_q;
	logic          data_vld_q;
	logic [15:0]   acc_q;
	logic [16:0]   acc_add;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= OSD_CK_IDLE;
		end else begin
			case (state_q)
				OSD_CK_IDLE:  if (start) state_q <= OSD_CK_RUN;
				OSD_CK_RUN:   if (rom_addr == OSD_ROM_LAST) state_q <= OSD_CK_DRAIN;
				OSD_CK_DRAIN: state_q <= OSD_CK_DONE;
				OSD_CK_DONE:  state_q <= OSD_CK_IDLE;
				default:      state_q <= OSD_CK_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rom_addr <= OSD_ROM_ADDR_RST;
		end else if (state_q == OSD_CK_RUN && rom_addr != OSD_ROM_LAST) begin
			rom_addr <= rom_addr + 13'h0001;
		end else if (state_q != OSD_CK_RUN) begin
			rom_addr <= OSD_ROM_ADDR_RST;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			data_vld_q <= 1'b0;
		end else begin
			data_vld_q <= (state_q == OSD_CK_RUN);
		end
	end

	always_comb begin
		acc_add = {1'b0, acc_q} + {5'h00, rom_data};
		if (acc_add >= OSD_CK_MODULUS) begin
			acc_add = acc_add - OSD_CK_MODULUS;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			acc_q <= OSD_CK_RES_RST;
		end else if (state_q == OSD_CK_IDLE) begin
			acc_q <= OSD_CK_RES_RST;
		end else if (data_vld_q) begin
			acc_q <= acc_add[15:0];
		end
	end

	assign done = (state_q == OSD_CK_DONE);
	assign sum  = acc_q;
endmodule

// >>> rtl/osd_regbank.sv
/*
 * On-screen display control bank: blanking length, character height,
 * three colour settings and the font ROM signature control and result.
 * Assumes the serial control front end presents one byte request per
 * cycle, and a font ROM answering one cycle after its address.
 */
`timescale 1ns/1ps

module osd_regbank
	import osd_pkg::*;
(
	input  wire logic                   CLK,          // 20 MHz system clock
	input  wire logic                   RST,          // async reset, high
	input  wire osd_pkg::osd_req_t      REG_REQ,      // byte register request
	output logic      [7:0]             REG_RDATA,    // read data, one cycle after rd
	output logic      [6:0]             VBLANK_LEN,   // vertical blank length, lines
	output logic      [7:0]             CHAR_HEIGHT,  // character height value
	output osd_pkg::osd_color_t         HIGHLIGHT,    // highlight colour
	output osd_pkg::osd_color_t         LOWLIGHT,     // lowlight colour
	output osd_pkg::osd_color_t         SHADOW,       // heavy lowlight/shadow colour
	input  wire logic [11:0]            ROM_DATA,     // font rom word
	output logic      [12:0]            ROM_ADDR,     // font rom address
	output logic                        CK_BUSY       // signature scan running
);
	import osd_pkg::*;

	logic [6:0]  vblank_length_q;
	logic [7:0]  char_height_q;
	logic        checksum_start_q;
	logic [15:0] checksum_result_q;
	logic [7:0]  rdata_q;
	logic [7:0]  rdata_d;
	logic        ck_done;
	logic [15:0] ck_sum;
	osd_color_t  high_c;
	osd_color_t  low_c;
	osd_color_t  shade_c;

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			vblank_length_q <= OSD_VBLANK_RST;
		end else if (REG_REQ.wr && REG_REQ.addr == OSD_ADR_VBLANK) begin
			vblank_length_q <= REG_REQ.wdata[OSD_VBLANK_MSB:0];
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			char_height_q <= OSD_CHAR_HT_RST;
		end else if (REG_REQ.wr && REG_REQ.addr == OSD_ADR_CHAR_HT) begin
			char_height_q <= REG_REQ.wdata;
		end
	end

	osd_color_reg #(
		.ADR_LO (OSD_ADR_HIGH_LO),
		.ADR_HI (OSD_ADR_HIGH_HI)
	) u_high (
		.clk   (CLK),
		.rst   (RST),
		.req   (REG_REQ),
		.color (high_c)
	);

	osd_color_reg #(
		.ADR_LO (OSD_ADR_LOW_LO),
		.ADR_HI (OSD_ADR_LOW_HI)
	) u_low (
		.clk   (CLK),
		.rst   (RST),
		.req   (REG_REQ),
		.color (low_c)
	);

	osd_color_reg #(
		.ADR_LO (OSD_ADR_SHADE_LO),
		.ADR_HI (OSD_ADR_SHADE_HI)
	) u_shade (
		.clk   (CLK),
		.rst   (RST),
		.req   (REG_REQ),
		.color (shade_c)
	);

	// colours retimed so the ports come from flops
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			HIGHLIGHT <= osd_color_t'(OSD_COLOR_RST);
			LOWLIGHT  <= osd_color_t'(OSD_COLOR_RST);
			SHADOW    <= osd_color_t'(OSD_COLOR_RST);
		end else begin
			HIGHLIGHT <= high_c;
			LOWLIGHT  <= low_c;
			SHADOW    <= shade_c;
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			checksum_start_q <= 1'b0;
		end else if (REG_REQ.wr && REG_REQ.addr == OSD_ADR_CK_CTRL && REG_REQ.wdata[OSD_CK_START_BIT]) begin
			checksum_start_q <= 1'b1;
		end else if (ck_done) begin
			checksum_start_q <= 1'b0;
		end
	end

	osd_cksum u_cksum (
		.clk      (CLK),
		.rst      (RST),
		.start    (checksum_start_q),
		.rom_data (ROM_DATA),
		.rom_addr (ROM_ADDR),
		.done     (ck_done),
		.sum      (ck_sum)
	);

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			checksum_result_q <= OSD_CK_RES_RST;
		end else if (ck_done) begin
			checksum_result_q <= ck_sum;
		end
	end

	always_comb begin
		rdata_d = 8'h00;
		if (REG_REQ.addr == OSD_ADR_VBLANK) begin
			rdata_d = {1'b0, vblank_length_q};
		end else if (REG_REQ.addr == OSD_ADR_CHAR_HT) begin
			rdata_d = char_height_q;
		end else if (REG_REQ.addr == OSD_ADR_HIGH_LO) begin
			rdata_d = high_c[7:0];
		end else if (REG_REQ.addr == OSD_ADR_HIGH_HI) begin
			rdata_d = {7'h00, high_c[OSD_COLOR_HI_BIT]};
		end else if (REG_REQ.addr == OSD_ADR_LOW_LO) begin
			rdata_d = low_c[7:0];
		end else if (REG_REQ.addr == OSD_ADR_LOW_HI) begin
			rdata_d = {7'h00, low_c[OSD_COLOR_HI_BIT]};
		end else if (REG_REQ.addr == OSD_ADR_SHADE_LO) begin
			rdata_d = shade_c[7:0];
		end else if (REG_REQ.addr == OSD_ADR_SHADE_HI) begin
			rdata_d = {7'h00, shade_c[OSD_COLOR_HI_BIT]};
		end else if (REG_REQ.addr == OSD_ADR_CK_CTRL) begin
			rdata_d = {7'h00, checksum_start_q};
		end else if (REG_REQ.addr == OSD_ADR_CK_RES_LO) begin
			rdata_d = checksum_result_q[7:0];
		end else if (REG_REQ.addr == OSD_ADR_CK_RES_HI) begin
			rdata_d = checksum_result_q[15:8];
		end
	end

	// read data held until the next read
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			rdata_q <= OSD_RDATA_RST;
		end else if (REG_REQ.rd) begin
			rdata_q <= rdata_d;
		end
	end

	assign REG_RDATA   = rdata_q;
	assign VBLANK_LEN  = vblank_length_q;
	assign CHAR_HEIGHT = char_height_q;
	assign CK_BUSY     = checksum_start_q;
endmodule

// >>> testbench/osd_regbank_sva.sv
/*
 * Port checker for the display control bank.
 * Assumes one host request at a time and the package constants.
 */
`timescale 1ns/1ps
module osd_regbank_sva
	import osd_pkg::*;
(
	input wire logic        CLK,         // clock
	input wire logic        RST,         // reset
	input wire osd_req_t    REG_REQ,     // request
	input wire logic [7:0]  REG_RDATA,   // read data
	input wire logic [6:0]  VBLANK_LEN,  // blank length
	input wire logic [7:0]  CHAR_HEIGHT, // height
	input wire osd_color_t  HIGHLIGHT,   // colour
	input wire osd_color_t  LOWLIGHT,    // colour
	input wire osd_color_t  SHADOW,      // colour
	input wire logic [11:0] ROM_DATA,    // rom word
	input wire logic [12:0] ROM_ADDR,    // rom address
	input wire logic        CK_BUSY      // scan running
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);
	a_vblank_write: assert property (REG_REQ.wr && REG_REQ.addr == OSD_ADR_VBLANK
		|=> VBLANK_LEN == $past(REG_REQ.wdata[6:0])) else $error("blank length not stored");
	a_color_write: assert property (REG_REQ.wr && REG_REQ.addr == OSD_ADR_HIGH_LO
		|-> ##2 HIGHLIGHT[7:0] == $past(REG_REQ.wdata, 2)) else $error("colour low byte lost");
	a_busy_start: assert property (REG_REQ.wr && REG_REQ.addr == OSD_ADR_CK_CTRL && REG_REQ.wdata[0]
		|=> CK_BUSY) else $error("scan not started");
	a_rom_idle: assert property (!CK_BUSY |-> ROM_ADDR == 13'h0000) else $error("rom address moves idle");
	a_rom_step: assert property (ROM_ADDR != 13'h0000 && ROM_ADDR != OSD_ROM_LAST
		|=> ROM_ADDR == $past(ROM_ADDR) + 13'h0001) else $error("rom scan skipped");
	// last address stays out through the drain cycle
	a_rom_wrap: assert property (ROM_ADDR == OSD_ROM_LAST |-> ##2 ROM_ADDR == 13'h0000)
		else $error("rom scan overran");
	a_unmapped_read: assert property (REG_REQ.rd && REG_REQ.addr == 16'h840B
		|=> REG_RDATA == 8'h00) else $error("unmapped read not zero");
	a_read_vblank: assert property (REG_REQ.rd && REG_REQ.addr == OSD_ADR_VBLANK
		|=> REG_RDATA == {1'b0, $past(VBLANK_LEN)}) else $error("blank readback wrong");
endmodule

bind osd_regbank osd_regbank_sva sva_u (.CLK(CLK), .RST(RST), .REG_REQ(REG_REQ), .REG_RDATA(REG_RDATA),
	.VBLANK_LEN(VBLANK_LEN), .CHAR_HEIGHT(CHAR_HEIGHT), .HIGHLIGHT(HIGHLIGHT), .LOWLIGHT(LOWLIGHT),
	.SHADOW(SHADOW), .ROM_DATA(ROM_DATA), .ROM_ADDR(ROM_ADDR), .CK_BUSY(CK_BUSY));

// >>> testbench/osd_host_model.sv
/*
 * Host controller model: one byte access per call.
 * Assumes the bank takes a request on the rising edge.
 */
`timescale 1ns/1ps
module osd_host_model
	import osd_pkg::*;
(
	input wire logic      clk, // clock
	output osd_pkg::osd_req_t req // request
);
	initial req = '0;
	// request held across the taking edge
	task automatic access(input logic w, input logic [15:0] a, input logic [7:0] d);
		@(negedge clk);
		req <= {w, ~w, a, d};
		@(negedge clk);
		// released bus shows no stale value
		req <= {2'b00, ~a, ~d};
	endtask
endmodule

// >>> testbench/tb_osd_control_and_rom_checksum.sv
/*
 * Self-checking bench for the display control bank.
 * Assumes the host model and a one-cycle font rom model here.
 */
`timescale 1ns/1ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin miscompares++; \
	$display("FAIL t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_osd_control_and_rom_checksum;
	import osd_pkg::*;
	logic        CLK = 1'b0;
	logic        RST = 1'b1;
	osd_req_t    req;
	logic [7:0]  rdata;
	logic [6:0]  vblank;
	logic [7:0]  height;
	osd_color_t  hl, ll, sh;
	logic [11:0] rom_data = 12'h000;
	logic [12:0] rom_addr;
	logic        busy;
	int          miscompares = 0;
	int          total_checks = 0;

	always #25 CLK = ~CLK;
	osd_host_model host_u (.clk(CLK), .req(req));
	osd_regbank dut_u (.CLK(CLK), .RST(RST), .REG_REQ(req), .REG_RDATA(rdata), .VBLANK_LEN(vblank),
		.CHAR_HEIGHT(height), .HIGHLIGHT(hl), .LOWLIGHT(ll), .SHADOW(sh), .ROM_DATA(rom_data),
		.ROM_ADDR(rom_addr), .CK_BUSY(busy));

	function automatic logic [11:0] rom_word(input logic [12:0] a);
		return 12'(a * 7) ^ 12'hA5C;
	endfunction
	always @(posedge CLK) rom_data <= rom_word(rom_addr);

	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		host_u.access(1'b0, a, 8'h00);
		`CHK(rdata, exp)
	endtask

	task automatic t_reset();
		for (int a = 16'h8403; a <= 16'h840F; a++) rd(16'(a), 8'h00);
	endtask

	task automatic t_fields();
		host_u.access(1'b1, 16'h8403, 8'h5B);
		`CHK(vblank, 7'h5B)
		rd(16'h8403, 8'h5B);
		host_u.access(1'b1, 16'h8404, 8'h51);
		`CHK(height, 8'h51)
		host_u.access(1'b1, 16'h840B, 8'h77);
		rd(16'h840B, 8'h00);
	endtask

	task automatic t_colors();
		logic [7:0] lo[3];
		lo = '{8'hA5, 8'h5A, 8'hC3};
		for (int i = 0; i < 3; i++) begin
			host_u.access(1'b1, 16'(16'h8405 + 2 * i), lo[i]);
			host_u.access(1'b1, 16'(16'h8406 + 2 * i), 8'h01);
		end
		@(negedge CLK);
		`CHK({hl, ll, sh}, {9'h1A5, 9'h15A, 9'h1C3})
		`CHK(hl.green, 3'b110)
		`CHK(sh.blue, 3'b011)
		for (int i = 0; i < 3; i++) begin
			rd(16'(16'h8405 + 2 * i), lo[i]);
			rd(16'(16'h8406 + 2 * i), 8'h01);
		end
	endtask

	task automatic t_cksum();
		int s;
		s = 0;
		for (int a = 0; a < OSD_CK_CHARS * OSD_CK_WORDS_CHAR; a++) begin
			s += rom_word(13'(a));
			if (s >= 65535) s -= 65535;
		end
		for (int k = 0; k < 2; k++) begin
			host_u.access(1'b1, 16'h840D, 8'h01);
			`CHK(busy, 1'b1)
			host_u.access(1'b1, 16'h840E, 8'hFF);
			host_u.access(1'b0, 16'h840D, 8'h00);
			for (int n = 0; n < 3000 && rdata[0] !== 1'b0; n++) host_u.access(1'b0, 16'h840D, 8'h00);
			`CHK(busy, 1'b0)
			rd(16'h840E, s[7:0]);
			rd(16'h840F, s[15:8]);
		end
		// inverted bytes so an accepted write would show
		host_u.access(1'b1, 16'h840E, ~s[7:0]);
		host_u.access(1'b1, 16'h840F, ~s[15:8]);
		rd(16'h840E, s[7:0]);
		rd(16'h840F, s[15:8]);
	endtask

	task automatic tally_and_finish();
		if (miscompares == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		#1000000;
		miscompares++;
		tally_and_finish();
	end

	initial begin
		repeat (5) @(posedge CLK);
		@(negedge CLK) RST = 1'b0;
		t_reset();
		t_fields();
		t_colors();
		t_cksum();
		tally_and_finish();
	end
endmodule
